/* dv/pmcs_chk.sv */
// Port checks for the power-management block.
`timescale 1ns/1ps
`default_nettype none
module pmcs_chk #(parameter logic BPCC_ON = 1'b1, parameter logic B2B3_SEL = 1'b1) (
    input wire logic clk,
    input wire logic nrst,
    input wire pmcs_pkg::pmcs_cfg_req_s cfg_req,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_ack,
    input wire logic wake_event,
    input wire logic wake_n_o,
    input wire logic wake_n_oe,
    input wire logic func_rst,
    input wire pmcs_pkg::pmcs_sec_bus_s sec_bus,
    input wire logic [1:0] power_state
);
    import pmcs_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    wire logic hit = cfg_req.addr[7:2] == 6'h29;
    wire logic clr = cfg_req.wr && hit && cfg_req.be[1];
    chk_zero_bits: assert property (cfg_ack |-> (cfg_rdata & 32'hff3f7efc) == 32'h0)
        else $error("zero bits set");
    chk_ext_fixed: assert property (cfg_req.rd && hit |=> cfg_rdata[23:16] == {BPCC_ON, B2B3_SEL, 6'h0})
        else $error("ext byte");
    chk_state_read: assert property (cfg_req.rd && hit |=> cfg_rdata[1:0] == $past(power_state))
        else $error("state read");
    chk_rst_cause: assert property (func_rst |-> $past(power_state) == 2'h3 && power_state == 2'h0)
        else $error("stray reset");
    chk_rst_pulse: assert property ($past(nrst) && $past(power_state) == 2'h3 && power_state == 2'h0 |-> func_rst)
        else $error("missing reset");
    chk_bus_action: assert property (sec_bus == ({BPCC_ON & B2B3_SEL, BPCC_ON & ~B2B3_SEL} & {2{power_state == 2'h3}}))
        else $error("bus action");
    chk_flag_clear: assert property (clr && cfg_req.wdata[15] && !wake_event |=> !wake_n_oe)
        else $error("flag clear");
    chk_en_gate: assert property (clr && !cfg_req.wdata[8] |=> !wake_n_oe && !wake_n_o)
        else $error("enable gate");
endmodule
bind pmcs_top pmcs_chk #(.BPCC_ON(BPCC_ON), .B2B3_SEL(B2B3_SEL)) pmcs_chk_inst (.clk, .nrst, .cfg_req, .cfg_rdata,
    .cfg_ack, .wake_event, .wake_n_o, .wake_n_oe, .func_rst, .sec_bus, .power_state);
`default_nettype wire

/* dv/pmcs_top_tb.sv */
// Directed test of the power-management register block.
`timescale 1ns/1ps
`default_nettype none
module pmcs_top_tb;
    import pmcs_pkg::*;
    logic clk, nrst, ev, ack, frst, oe, wo, pin;
    logic [31:0] rdata;
    logic [1:0] ps;
    pmcs_cfg_req_s req;
    pmcs_sec_bus_s sb;
    int num_errors = 0;
    int comparisons = 0;
    pmcs_top pmcs_top_inst (.clk(clk), .nrst(nrst), .cfg_req(req), .cfg_rdata(rdata), .cfg_ack(ack),
        .wake_event(ev), .wake_n_o(wo), .wake_n_oe(oe), .func_rst(frst), .sec_bus(sb), .power_state(ps));
    pmcs_wake_pull pmcs_wake_pull_inst (.drv_o(wo), .drv_oe(oe), .pin(pin));
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Answer is registered on the taking edge, so sample just after it
    task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge clk);
        #1 req = '{rd: !w, wr: w, addr: a, be: be, wdata: d};
        @(posedge clk);
        #1 req = '0;
        cmp(ack, 1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        acc(0, a, 4'h0, 32'h0);
        cmp(rdata, exp);
    endtask
    task automatic results();
        if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #20000;
        num_errors++;
        results();
    end
    initial begin
        req = '0;
        ev = 0;
        nrst = 0;
        repeat (2) @(posedge clk);
        #1 nrst = 1;
        rd(8'ha4, 32'h00c00000);
        rd(8'h10, 32'h0);
        acc(1, 8'ha4, 4'hf, 32'hfffffefe);
        rd(8'ha4, 32'h00c00002);
        for (int s = 1; s < 4; s++) begin
            acc(1, 8'ha4, 4'h1, s);
            cmp(ps, s);
            cmp(sb, s == 3 ? 32'h2 : 32'h0);
            rd(8'ha4, 32'h00c00000 | s);
        end
        acc(1, 8'ha4, 4'h2, 32'h100);
        ev = 1;
        @(posedge clk);
        #1 ev = 0;
        cmp(pin, 0);
        acc(1, 8'ha4, 4'h1, 32'h0);
        cmp(frst, 1);
        cmp(ps, 0);
        rd(8'ha4, 32'h00c08100);
        acc(1, 8'ha4, 4'h2, 32'h100);
        rd(8'ha4, 32'h00c08100);
        acc(1, 8'ha4, 4'h2, 32'h8100);
        cmp(pin, 1);
        acc(1, 8'ha6, 4'hc, 32'hffffffff);
        rd(8'ha4, 32'h00c00100);
        acc(1, 8'ha4, 4'h2, 32'h0);
        ev = 1;
        @(posedge clk);
        #1 ev = 0;
        cmp(pin, 1);
        rd(8'ha4, 32'h00c08000);
        nrst = 0;
        repeat (2) @(posedge clk);
        #1 nrst = 1;
        rd(8'ha4, 32'h00c00000);
        cmp(ps, 0);
        results();
    end
endmodule
`default_nettype wire

/* dv/pmcs_wake_pull.sv */
// Pull-up model of the open-drain wake line.
`timescale 1ns/1ps
`default_nettype none
module pmcs_wake_pull (
    input wire logic drv_o,
    input wire logic drv_oe,
    output wire logic pin
);
    // Released line rises to the pull-up, never keeps the last driven level
    assign pin = drv_oe ? drv_o : 1'b1;
endmodule
`default_nettype wire

/* verilog/pmcs_pkg.sv */
// Package for the power-management control/status block: offsets, fields, types.
`default_nettype none
package pmcs_pkg;
    // ==========================================================
    // Configuration offsets (byte addresses in config space)
    localparam logic [7:0] PMCS_OFF_CSR = 8'ha4;
    localparam logic [7:0] PMCS_OFF_BSE = 8'ha6;
    // ==========================================================
    // Control/status field positions
    localparam int PMCS_BIT_WAKE_FLAG = 15;
    localparam int PMCS_BIT_WAKE_EN = 8;
    localparam int PMCS_BIT_PS_LO = 0;
    // ==========================================================
    // Bridge extension fields and reset values
    localparam int PMCS_BIT_BPCC = 7;
    localparam int PMCS_BIT_B2B3 = 6;
    localparam logic [7:0] PMCS_BSE_RESET = 8'hc0;
    localparam logic [15:0] PMCS_CSR_RESET = 16'h0000;
    // Writable bits of the control/status word
    localparam logic [15:0] PMCS_CSR_WMASK = 16'h0103;
    // ==========================================================
    // Power states
    typedef enum logic [1:0] {
        PMCS_D0 = 2'h0,
        PMCS_D1 = 2'h1,
        PMCS_D2 = 2'h2,
        PMCS_D3HOT = 2'h3
    } pmcs_pstate_e;
    // ==========================================================
    // Configuration access bundle
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } pmcs_cfg_req_s;
    // Secondary bus controls
    typedef struct packed {
        logic clk_stop;
        logic pwr_off;
    } pmcs_sec_bus_s;
endpackage
`default_nettype wire

/* verilog/pmcs_rst_gen.sv */
// One-cycle internal reset pulse on the D3hot to D0 transition.
`timescale 1ns/1ps
`default_nettype none
module pmcs_rst_gen (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [1:0] state_q,
    input wire logic [1:0] state_d,
    output logic func_rst
);
    import pmcs_pkg::*;
    // ==========================================================
    // Transition detect
    always_ff @(posedge clk) begin
        if (!nrst) begin
            func_rst <= 1'b0;
        end else begin
            func_rst <= (state_q == PMCS_D3HOT) && (state_d == PMCS_D0);
        end
    end
endmodule
`default_nettype wire

/* verilog/pmcs_top.sv */
// Power-management control/status and bridge extension registers.
`timescale 1ns/1ps
`default_nettype none
module pmcs_top #(
    parameter logic BPCC_ON = 1'b1,
    parameter logic B2B3_SEL = 1'b1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire pmcs_pkg::pmcs_cfg_req_s cfg_req,
    output logic [31:0] cfg_rdata,
    output logic cfg_ack,
    input wire logic wake_event,
    output logic wake_n_o,
    output logic wake_n_oe,
    output logic func_rst,
    output pmcs_pkg::pmcs_sec_bus_s sec_bus,
    output logic [1:0] power_state
);
    import pmcs_pkg::*;
    logic wake_flag_q;
    logic wake_en_q;
    logic [1:0] state_q;
    logic [1:0] state_d;
    logic hit_csr;
    logic wr_csr_lo;
    logic wr_csr_hi;
    logic [15:0] csr_word;
    logic [7:0] bse_byte;

    // Used by both secondary-bus outputs
    function automatic logic is_d3hot(input logic [1:0] st);
        return st == PMCS_D3HOT;
    endfunction

    // ==========================================================
    // Decode: one dword holds A4..A7; A6 is the extension byte
    assign hit_csr = (cfg_req.addr[7:2] == PMCS_OFF_CSR[7:2]);
    assign wr_csr_lo = cfg_req.wr && hit_csr && cfg_req.be[0];
    assign wr_csr_hi = cfg_req.wr && hit_csr && cfg_req.be[1];

    // ==========================================================
    // Power state
    always_comb begin
        state_d = state_q;
        if (wr_csr_lo) begin
            state_d = cfg_req.wdata[PMCS_BIT_PS_LO +: 2];
        end
    end

    // Not touched by func_rst: the function reset spares this register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_q <= PMCS_D0;
        end else begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // Wake enable and flag
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wake_en_q <= 1'b0;
        end else if (wr_csr_hi) begin
            wake_en_q <= cfg_req.wdata[PMCS_BIT_WAKE_EN];
        end
    end

    // Set beats clear so an event in the clearing cycle is kept
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wake_flag_q <= 1'b0;
        end else if (wake_event) begin
            wake_flag_q <= 1'b1;
        end else if (wr_csr_hi && cfg_req.wdata[PMCS_BIT_WAKE_FLAG]) begin
            wake_flag_q <= 1'b0;
        end
    end

    // Open-drain wake pin: only ever pulled low
    assign wake_n_o = 1'b0;
    assign wake_n_oe = wake_flag_q && wake_en_q;

    // ==========================================================
    // Function reset
    pmcs_rst_gen u_rst (
        .clk(clk),
        .nrst(nrst),
        .state_q(state_q),
        .state_d(state_d),
        .func_rst(func_rst)
    );

    // ==========================================================
    // Secondary bus control
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sec_bus <= '0;
        end else if (BPCC_ON) begin
            sec_bus.clk_stop <= is_d3hot(state_d) && B2B3_SEL;
            sec_bus.pwr_off <= is_d3hot(state_d) && !B2B3_SEL;
        end else begin
            sec_bus <= '0;
        end
    end

    assign power_state = state_q;

    // ==========================================================
    // Read data: fixed zeros for scale, select, dynamic enable and reserved
    always_comb begin
        csr_word = PMCS_CSR_RESET;
        csr_word[PMCS_BIT_WAKE_FLAG] = wake_flag_q;
        csr_word[PMCS_BIT_WAKE_EN] = wake_en_q;
        csr_word[PMCS_BIT_PS_LO +: 2] = state_q;
        bse_byte = 8'h00;
        bse_byte[PMCS_BIT_BPCC] = BPCC_ON;
        bse_byte[PMCS_BIT_B2B3] = B2B3_SEL;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cfg_rdata <= 32'h0000_0000;
            cfg_ack <= 1'b0;
        end else begin
            cfg_ack <= cfg_req.rd || cfg_req.wr;
            if (cfg_req.rd && hit_csr) begin
                cfg_rdata <= {8'h00, bse_byte, csr_word};
            end else begin
                cfg_rdata <= 32'h0000_0000;
            end
        end
    end
endmodule
`default_nettype wire
